// ===== verilog/flash_seq_regs.svh
// Purpose: named constants for the flash command sequencer and its controller
// Assumes: byte addresses, word-wide array, 50 MHz system clock
// Notes: definitions only
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

`define FS_ADDR_W 24
`define FS_DATA_W 16
`define FS_WORD_AW 17
`define FS_SECT_WORDS 18'h00800
`define FS_CHIP_WORDS 18'h20000

// command offsets (low 12 address bits) and codes
`define FS_UNLOCK_A 12'hAAA
`define FS_UNLOCK_B 12'h554
`define FS_PROT_OFS 12'h77E
`define FS_KEY_A 8'hAA
`define FS_KEY_B 8'h55
`define FS_CMD_PROG 8'hA0
`define FS_CMD_ERASE 8'h80
`define FS_CMD_SECT 8'h30
`define FS_CMD_CHIP 8'h10
`define FS_CMD_ID 8'h90
`define FS_CMD_EXIT 8'hF0
`define FS_CMD_PROT 8'hA5
`define FS_PROT_RD 8'hF0
`define FS_PROT_WR 8'h0F
`define FS_ERASED 16'hFFFF
`define FS_PROT_NONE 8'hFF

// identification read offsets
`define FS_ID_VENDOR_OFS 12'h000
`define FS_ID_MACRO_OFS 12'h002
`define FS_ID_SIZE_OFS 12'h004

// status bit positions
`define FS_POLL_BIT 7
`define FS_TOGGLE_BIT 6

// timing: longest program / protect time rounds down to whole cycles
`define FS_CLK_KHZ 50000
`define FS_PROG_US 60
`define FS_PROG_CYC ((`FS_PROG_US * `FS_CLK_KHZ) / 1000)
`define FS_SECT_ERASE_MS 75
`define FS_CHIP_ERASE_MS 300

// controller register offsets
`define HC_CTRL_OFS 8'h00
`define HC_ADDR_OFS 8'h04
`define HC_DATA_OFS 8'h08
`define HC_STAT_OFS 8'h0C
`define HC_RDATA_OFS 8'h10
`define HC_STAT_BUSY 0
`define HC_STAT_DONE 1

`endif

// ===== verilog/flash_seq_pkg.sv
// Purpose: types shared by the sequencer and its controller
// Assumes: nothing beyond the constants header
// Notes: state encodings are gray in declaration order
package flash_seq_pkg;

   typedef enum logic [3:0] {
      DS_IDLE = 4'h0,
      DS_UNL1 = 4'h1,
      DS_UNL2 = 4'h3,
      DS_ERS1 = 4'h2,
      DS_ERS2 = 4'h6,
      DS_ERS3 = 4'h7,
      DS_PROG = 4'h5,
      DS_PROT = 4'h4,
      DS_BUSY = 4'hC
   } dev_state_t;

   typedef enum logic [1:0] {
      AO_PROG = 2'h0,
      AO_ERASE = 2'h1,
      AO_PROT = 2'h2
   } auto_op_t;

   typedef enum logic [2:0] {
      OP_PROG = 3'h0,
      OP_SECT = 3'h1,
      OP_CHIP = 3'h2,
      OP_ID_ENTRY = 3'h3,
      OP_ID_EXIT = 3'h4,
      OP_RPROT = 3'h5,
      OP_WPROT = 3'h6,
      OP_READ = 3'h7
   } host_op_t;

   typedef enum logic [2:0] {
      HS_IDLE = 3'h0,
      HS_WRITE = 3'h1,
      HS_ISSUE = 3'h3,
      HS_WAIT = 3'h2,
      HS_CAP = 3'h6
   } host_state_t;

endpackage : flash_seq_pkg

// ===== verilog/flash_bus_if.sv
// Purpose: bus between the issuing core and the flash sequencer
// Assumes: one clock; read data stand in the cycle after the read strobe
// Notes: strobes are single-cycle and never both high
`timescale 1ns/100ps
`include "flash_seq_regs.svh"

interface flash_bus_if;
   logic [`FS_ADDR_W-1:0] addr;
   logic [`FS_DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [`FS_DATA_W-1:0] rdata;

   modport dev (input addr, input wdata, input wr, input rd, output rdata);
   modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : flash_bus_if

// ===== verilog/flash_command_sequencer.sv
// Purpose: command decoder and auto-operation sequencer for a word-wide flash array
// Assumes: the core issues byte addresses within the array's mapped region
// Notes: erase walks the array one word per cycle, well inside the allowed time
`timescale 1ns/100ps
`include "flash_seq_regs.svh"

module flash_command_sequencer #(
   parameter logic [7:0] VENDOR_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] MACRO_ID = 8'h11,  // arbitrary value
   parameter logic [7:0] SIZE_ID = 8'h22    // arbitrary value
) (
   input wire logic sys_clk,        // system clock, 50 MHz
   input wire logic sys_rst,        // synchronous reset, active high
   flash_bus_if.dev bus,            // core-side bus
   input wire logic programmer_pin, // high when the part runs in programmer mode
   output logic ident_active,       // identification mode is on
   output logic auto_busy,          // an auto operation is running
   output logic read_protected,     // read protection is set
   output logic write_protected     // write protection is set
);

   localparam logic [17:0] PROG_LAST = 18'(`FS_PROG_CYC - 1);

   flash_seq_pkg::dev_state_t state_q, state_d;
   flash_seq_pkg::auto_op_t op_q, op_d;
   logic [17:0] cnt_q, cnt_d;
   logic [17:0] last_q, last_d;
   logic [`FS_WORD_AW-1:0] base_q, base_d;
   logic [`FS_DATA_W-1:0] pdata_q, pdata_d;
   logic ident_q, ident_d;
   logic tog_q, tog_d;
   logic [7:0] prot_q, prot_d;
   logic [`FS_DATA_W-1:0] rdata_q, rdata_d;
   logic pm_meta_q, pm_q;

   logic [`FS_DATA_W-1:0] mem [0:(1 << `FS_WORD_AW)-1];
   logic mem_we;
   logic [`FS_WORD_AW-1:0] mem_waddr;
   logic [`FS_DATA_W-1:0] mem_wdata;

   logic [11:0] lo;
   logic [7:0] cd;
   logic [`FS_WORD_AW-1:0] word_idx;

   assign lo = bus.addr[11:0];
   assign cd = bus.wdata[7:0];
   assign word_idx = bus.addr[`FS_WORD_AW:1];

   assign ident_active = ident_q;
   assign auto_busy = (state_q == flash_seq_pkg::DS_BUSY);
   assign read_protected = (prot_q == `FS_PROT_RD);
   assign write_protected = (prot_q == `FS_PROT_WR);
   assign bus.rdata = rdata_q;

   // programmer-mode strap comes from a pin
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pm_meta_q <= 1'b0;
         pm_q <= 1'b0;
      end else begin
         pm_meta_q <= programmer_pin;
         pm_q <= pm_meta_q;
      end
   end

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cnt_d = cnt_q;
      last_d = last_q;
      base_d = base_q;
      pdata_d = pdata_q;
      ident_d = ident_q;
      tog_d = tog_q;
      prot_d = prot_q;
      rdata_d = rdata_q;
      mem_we = 1'b0;
      mem_waddr = base_q;
      mem_wdata = `FS_ERASED;

      if (state_q == flash_seq_pkg::DS_BUSY) begin
         // writes are ignored here: no command is taken while busy
         cnt_d = cnt_q + 18'h00001;
         if (op_q == flash_seq_pkg::AO_ERASE) begin
            mem_we = 1'b1;
            mem_waddr = base_q + cnt_q[`FS_WORD_AW-1:0];
         end else if (op_q == flash_seq_pkg::AO_PROG && cnt_q == last_q) begin
            mem_we = 1'b1;
            mem_wdata = pdata_q;
         end
         if (cnt_q == last_q) begin
            state_d = flash_seq_pkg::DS_IDLE;
            if (op_q == flash_seq_pkg::AO_PROT) begin
               prot_d = pdata_q[7:0];
            end
         end
      end else if (bus.wr) begin
         state_d = flash_seq_pkg::DS_IDLE;
         case (state_q)
            flash_seq_pkg::DS_IDLE: begin
               if (lo == `FS_UNLOCK_A && cd == `FS_KEY_A) begin
                  state_d = flash_seq_pkg::DS_UNL1;
               end else if (cd == `FS_CMD_EXIT) begin
                  ident_d = 1'b0;
               end
            end
            flash_seq_pkg::DS_UNL1: begin
               if (lo == `FS_UNLOCK_B && cd == `FS_KEY_B) begin
                  state_d = flash_seq_pkg::DS_UNL2;
               end
            end
            flash_seq_pkg::DS_UNL2: begin
               if (lo == `FS_UNLOCK_A) begin
                  if (cd == `FS_CMD_PROG) begin
                     state_d = flash_seq_pkg::DS_PROG;
                  end else if (cd == `FS_CMD_ERASE) begin
                     state_d = flash_seq_pkg::DS_ERS1;
                  end else if (cd == `FS_CMD_PROT) begin
                     state_d = flash_seq_pkg::DS_PROT;
                  end else if (cd == `FS_CMD_ID) begin
                     ident_d = 1'b1;
                  end else if (cd == `FS_CMD_EXIT) begin
                     ident_d = 1'b0;
                  end
               end
            end
            flash_seq_pkg::DS_ERS1: begin
               if (lo == `FS_UNLOCK_A && cd == `FS_KEY_A) begin
                  state_d = flash_seq_pkg::DS_ERS2;
               end
            end
            flash_seq_pkg::DS_ERS2: begin
               if (lo == `FS_UNLOCK_B && cd == `FS_KEY_B) begin
                  state_d = flash_seq_pkg::DS_ERS3;
               end
            end
            flash_seq_pkg::DS_ERS3: begin
               if (cd == `FS_CMD_SECT && !pm_q) begin
                  state_d = flash_seq_pkg::DS_BUSY;
                  op_d = flash_seq_pkg::AO_ERASE;
                  // upper sector bits beyond the array fold away
                  base_d = {bus.addr[`FS_WORD_AW:12], 11'h000};
                  last_d = `FS_SECT_WORDS - 18'h00001;
                  cnt_d = 18'h00000;
                  tog_d = 1'b1;
               end else if (lo == `FS_UNLOCK_A && cd == `FS_CMD_CHIP) begin
                  state_d = flash_seq_pkg::DS_BUSY;
                  op_d = flash_seq_pkg::AO_ERASE;
                  base_d = '0;
                  last_d = `FS_CHIP_WORDS - 18'h00001;
                  cnt_d = 18'h00000;
                  tog_d = 1'b1;
                  prot_d = `FS_PROT_NONE; // chip erase lifts protection
               end
            end
            flash_seq_pkg::DS_PROG: begin
               state_d = flash_seq_pkg::DS_BUSY;
               op_d = flash_seq_pkg::AO_PROG;
               base_d = word_idx; // bit 0 dropped: word aligned
               pdata_d = bus.wdata;
               last_d = PROG_LAST;
               cnt_d = 18'h00000;
               tog_d = 1'b1;
            end
            flash_seq_pkg::DS_PROT: begin
               if (lo == `FS_PROT_OFS && (cd == `FS_PROT_RD || cd == `FS_PROT_WR)) begin
                  state_d = flash_seq_pkg::DS_BUSY;
                  op_d = flash_seq_pkg::AO_PROT;
                  pdata_d = bus.wdata;
                  last_d = PROG_LAST;
                  cnt_d = 18'h00000;
                  tog_d = 1'b1;
               end
            end
            default: begin
               state_d = flash_seq_pkg::DS_IDLE;
            end
         endcase
      end

      if (bus.rd) begin
         if (state_q == flash_seq_pkg::DS_BUSY) begin
            rdata_d = '0;
            rdata_d[`FS_TOGGLE_BIT] = tog_q;
            tog_d = ~tog_q;
            if (op_q == flash_seq_pkg::AO_PROG) begin
               rdata_d[`FS_POLL_BIT] = ~pdata_q[`FS_POLL_BIT];
            end
         end else if (ident_q) begin
            rdata_d = '0;
            if (lo == `FS_ID_VENDOR_OFS) begin
               rdata_d[7:0] = VENDOR_ID;
            end else if (lo == `FS_ID_MACRO_OFS) begin
               rdata_d[7:0] = MACRO_ID;
            end else if (lo == `FS_ID_SIZE_OFS) begin
               rdata_d[7:0] = SIZE_ID;
            end else if (lo == `FS_PROT_OFS) begin
               rdata_d[7:0] = prot_q;
            end
         end else begin
            rdata_d = mem[word_idx];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= flash_seq_pkg::DS_IDLE;
         op_q <= flash_seq_pkg::AO_PROG;
         cnt_q <= 18'h00000;
         last_q <= 18'h00000;
         base_q <= '0;
         pdata_q <= 16'h0000;
         ident_q <= 1'b0;
         tog_q <= 1'b1;
         prot_q <= `FS_PROT_NONE;
         rdata_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         last_q <= last_d;
         base_q <= base_d;
         pdata_q <= pdata_d;
         ident_q <= ident_d;
         tog_q <= tog_d;
         prot_q <= prot_d;
         rdata_q <= rdata_d;
      end
   end

   // array contents survive reset, as flash cells do
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

endmodule : flash_command_sequencer

// ===== verilog/flash_seq_controller.sv
// Purpose: core-side engine issuing flash command sequences and polling completion
// Assumes: software writes ADDR and DATA before starting an operation
// Notes: a polled operation completes on two equal consecutive reads; no time-out is kept
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "flash_seq_regs.svh"

module flash_seq_controller (
   input wire logic sys_clk,          // system clock, 50 MHz
   input wire logic sys_rst,          // synchronous reset, active high
   input wire logic [7:0] reg_addr,   // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr,           // register write strobe
   input wire logic reg_rd,           // register read strobe
   output logic [31:0] reg_rdata,     // register read data, cycle after strobe
   flash_bus_if.host bus              // flash-side bus
);

   flash_seq_pkg::host_state_t state_q, state_d;
   flash_seq_pkg::host_op_t op_q, op_d;
   logic [2:0] step_q, step_d;
   logic [`FS_ADDR_W-1:0] uaddr_q, uaddr_d;
   logic [`FS_DATA_W-1:0] udata_q, udata_d;
   logic [`FS_DATA_W-1:0] prev_q, prev_d;
   logic have_prev_q, have_prev_d;
   logic done_q, done_d;
   logic [`FS_DATA_W-1:0] rres_q, rres_d;
   logic [31:0] rrd_q, rrd_d;
   logic [`FS_ADDR_W-1:0] baddr_q, baddr_d;
   logic [`FS_DATA_W-1:0] bdata_q, bdata_d;
   logic bwr_q, bwr_d;
   logic brd_q, brd_d;
   logic [2:0] nsteps;
   logic polls;
   logic [`FS_ADDR_W-1:0] cmd_a, cmd_b, poll_addr;
   logic [7:0] code3;

   assign bus.addr = baddr_q;
   assign bus.wdata = bdata_q;
   assign bus.wr = bwr_q;
   assign bus.rd = brd_q;
   assign reg_rdata = rrd_q;

   // unlock addresses carry the user address' upper bits to stay in region
   assign cmd_a = {uaddr_q[`FS_ADDR_W-1:12], `FS_UNLOCK_A};
   assign cmd_b = {uaddr_q[`FS_ADDR_W-1:12], `FS_UNLOCK_B};

   always_comb begin
      nsteps = 3'h0;
      polls = 1'b0;
      code3 = `FS_CMD_ID;
      poll_addr = uaddr_q;
      case (op_q)
         flash_seq_pkg::OP_PROG: begin
            nsteps = 3'h4;
            polls = 1'b1;
            code3 = `FS_CMD_PROG;
            poll_addr = {uaddr_q[`FS_ADDR_W-1:1], 1'b0};
         end
         flash_seq_pkg::OP_SECT, flash_seq_pkg::OP_CHIP: begin
            nsteps = 3'h6;
            polls = 1'b1;
            code3 = `FS_CMD_ERASE;
         end
         flash_seq_pkg::OP_ID_ENTRY: begin
            nsteps = 3'h3;
         end
         flash_seq_pkg::OP_ID_EXIT: begin
            nsteps = 3'h1;
         end
         flash_seq_pkg::OP_RPROT, flash_seq_pkg::OP_WPROT: begin
            nsteps = 3'h4;
            polls = 1'b1;
            code3 = `FS_CMD_PROT;
            poll_addr = {uaddr_q[`FS_ADDR_W-1:12], `FS_PROT_OFS};
         end
         default: begin
            nsteps = 3'h0;
         end
      endcase
   end

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      step_d = step_q;
      uaddr_d = uaddr_q;
      udata_d = udata_q;
      prev_d = prev_q;
      have_prev_d = have_prev_q;
      done_d = done_q;
      rres_d = rres_q;
      rrd_d = 32'h00000000;
      baddr_d = baddr_q;
      bdata_d = bdata_q;
      bwr_d = 1'b0;
      brd_d = 1'b0;

      if (reg_wr) begin
         if (reg_addr == `HC_ADDR_OFS) begin
            uaddr_d = reg_wdata[`FS_ADDR_W-1:0];
         end else if (reg_addr == `HC_DATA_OFS) begin
            udata_d = reg_wdata[`FS_DATA_W-1:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `HC_ADDR_OFS) begin
            rrd_d = {8'h00, uaddr_q};
         end else if (reg_addr == `HC_DATA_OFS) begin
            rrd_d = {16'h0000, udata_q};
         end else if (reg_addr == `HC_STAT_OFS) begin
            rrd_d[`HC_STAT_BUSY] = (state_q != flash_seq_pkg::HS_IDLE);
            rrd_d[`HC_STAT_DONE] = done_q;
         end else if (reg_addr == `HC_RDATA_OFS) begin
            rrd_d = {16'h0000, rres_q};
         end
      end

      case (state_q)
         flash_seq_pkg::HS_IDLE: begin
            // a start written while busy is dropped
            if (reg_wr && reg_addr == `HC_CTRL_OFS) begin
               op_d = flash_seq_pkg::host_op_t'(reg_wdata[2:0]);
               step_d = 3'h0;
               done_d = 1'b0;
               have_prev_d = 1'b0;
               state_d = (reg_wdata[2:0] == 3'h7) ? flash_seq_pkg::HS_ISSUE
                                                  : flash_seq_pkg::HS_WRITE;
            end
         end
         flash_seq_pkg::HS_WRITE: begin
            bwr_d = 1'b1;
            step_d = step_q + 3'h1;
            case (step_q)
               3'h0: begin
                  baddr_d = cmd_a;
                  bdata_d = {8'h00, `FS_KEY_A};
                  if (op_q == flash_seq_pkg::OP_ID_EXIT) begin
                     bdata_d = {8'h00, `FS_CMD_EXIT};
                  end
               end
               3'h1: begin
                  baddr_d = cmd_b;
                  bdata_d = {8'h00, `FS_KEY_B};
               end
               3'h2: begin
                  baddr_d = cmd_a;
                  bdata_d = {8'h00, code3};
               end
               3'h3: begin
                  if (op_q == flash_seq_pkg::OP_PROG) begin
                     baddr_d = {uaddr_q[`FS_ADDR_W-1:1], 1'b0};
                     bdata_d = udata_q;
                  end else if (op_q == flash_seq_pkg::OP_RPROT) begin
                     baddr_d = poll_addr;
                     bdata_d = {8'h00, `FS_PROT_RD};
                  end else if (op_q == flash_seq_pkg::OP_WPROT) begin
                     baddr_d = poll_addr;
                     bdata_d = {8'h00, `FS_PROT_WR};
                  end else begin
                     baddr_d = cmd_a;
                     bdata_d = {8'h00, `FS_KEY_A};
                  end
               end
               3'h4: begin
                  baddr_d = cmd_b;
                  bdata_d = {8'h00, `FS_KEY_B};
               end
               default: begin
                  if (op_q == flash_seq_pkg::OP_SECT) begin
                     baddr_d = uaddr_q;
                     bdata_d = {8'h00, `FS_CMD_SECT};
                  end else begin
                     baddr_d = cmd_a;
                     bdata_d = {8'h00, `FS_CMD_CHIP};
                  end
               end
            endcase
            if (step_q == nsteps - 3'h1) begin
               if (polls) begin
                  state_d = flash_seq_pkg::HS_ISSUE;
               end else begin
                  state_d = flash_seq_pkg::HS_IDLE;
                  done_d = 1'b1;
               end
            end
         end
         flash_seq_pkg::HS_ISSUE: begin
            brd_d = 1'b1;
            baddr_d = poll_addr;
            state_d = flash_seq_pkg::HS_WAIT;
         end
         flash_seq_pkg::HS_WAIT: begin
            state_d = flash_seq_pkg::HS_CAP;
         end
         flash_seq_pkg::HS_CAP: begin
            rres_d = bus.rdata;
            prev_d = bus.rdata;
            have_prev_d = 1'b1;
            // two equal reads in a row mean the auto operation is over
            if (op_q == flash_seq_pkg::OP_READ || (have_prev_q && prev_q == bus.rdata)) begin
               state_d = flash_seq_pkg::HS_IDLE;
               done_d = 1'b1;
            end else begin
               state_d = flash_seq_pkg::HS_ISSUE;
            end
         end
         default: begin
            state_d = flash_seq_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= flash_seq_pkg::HS_IDLE;
         op_q <= flash_seq_pkg::OP_READ;
         step_q <= 3'h0;
         uaddr_q <= 24'h000000;
         udata_q <= 16'h0000;
         prev_q <= 16'h0000;
         have_prev_q <= 1'b0;
         done_q <= 1'b0;
         rres_q <= 16'h0000;
         rrd_q <= 32'h00000000;
         baddr_q <= 24'h000000;
         bdata_q <= 16'h0000;
         bwr_q <= 1'b0;
         brd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         step_q <= step_d;
         uaddr_q <= uaddr_d;
         udata_q <= udata_d;
         prev_q <= prev_d;
         have_prev_q <= have_prev_d;
         done_q <= done_d;
         rres_q <= rres_d;
         rrd_q <= rrd_d;
         baddr_q <= baddr_d;
         bdata_q <= bdata_d;
         bwr_q <= bwr_d;
         brd_q <= brd_d;
      end
   end

endmodule : flash_seq_controller

// ===== test/flash_bus_monitor.sv
// Purpose: checks on the bus between the flash controller and the sequencer
// Assumes: the controller issues only well-formed sequences with a gap between busy reads
// Notes: operation kind is inferred from the code write that precedes the last write
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module flash_bus_monitor (
   input wire logic sys_clk, // system clock
   input wire logic sys_rst, // sync reset
   input wire logic [23:0] addr, // byte address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [15:0] rdata, // read data
   input wire logic programmer_pin, // programmer mode
   input wire logic auto_busy // auto operation running
);
   logic [7:0] prv_q;
   logic [11:0] cnt_q;
   logic prog_q, prot_q, pd7_q, first_q, rdd_q, p6_q;
   logic tog_bit, poll_bit;
   assign tog_bit = rdata[`FS_TOGGLE_BIT];
   assign poll_bit = rdata[`FS_POLL_BIT];
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prv_q <= 8'h00;
         prog_q <= 1'b0;
         prot_q <= 1'b0;
         pd7_q <= 1'b0;
      end else if (wr) begin
         prv_q <= wdata[7:0];
         prog_q <= prv_q == `FS_CMD_PROG;
         prot_q <= prv_q == `FS_CMD_PROT;
         pd7_q <= wdata[`FS_POLL_BIT];
      end
      // counter wraps on long erases, which are not bounded here
      cnt_q <= (auto_busy && !sys_rst) ? cnt_q + 12'h001 : 12'h000;
      first_q <= sys_rst || !auto_busy || (first_q && !rd);
      rdd_q <= rd && auto_busy && !sys_rst;
      if (rdd_q)
         p6_q <= tog_bit;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   chk_first_toggle: assert property (rd && auto_busy && first_q |=> tog_bit)
      else $error("first busy read lacks toggle bit");
   chk_toggle_alt: assert property (rd && auto_busy && !first_q |=> tog_bit != p6_q)
      else $error("toggle bit did not alternate");
   chk_poll_prog: assert property (rd && auto_busy && prog_q |=> poll_bit == !pd7_q)
      else $error("polling bit not inverted during program");
   chk_poll_zero: assert property (rd && auto_busy && !prog_q |=> !poll_bit)
      else $error("polling bit not zero during erase or protect");
   chk_busy_start: assert property (wr && prv_q == `FS_CMD_PROG |=> auto_busy)
      else $error("program did not start");
   chk_busy_limit: assert property (auto_busy && (prog_q || prot_q)
      |-> cnt_q < `FS_PROG_CYC)
      else $error("program or protect ran too long");
   chk_even_addr: assert property (wr && prv_q == `FS_CMD_PROG |-> !addr[0])
      else $error("odd program address");
   chk_unlock_pair: assert property (wr && addr[11:0] == `FS_UNLOCK_A
      && wdata[7:0] == `FS_KEY_A
      |=> wr && addr[11:0] == `FS_UNLOCK_B && wdata[7:0] == `FS_KEY_B)
      else $error("second unlock write missing");
   // prv_q holds the final write's code here: chip erase runs in either mode
   chk_erase_final: assert property (wr && wdata[7:0] == `FS_CMD_ERASE ##3 wr
      |=> auto_busy == (!programmer_pin || prv_q == `FS_CMD_CHIP))
      else $error("erase start wrong for mode");
   cover property (wr && prv_q == `FS_CMD_PROG);
   cover property (auto_busy && prot_q);
   cover property (rd && auto_busy && !prog_q && !prot_q);
endmodule : flash_bus_monitor

// ===== test/flash_command_sequencer_bench.sv
// Purpose: drives the controller registers and checks the flash results
// Assumes: chip erase is too long for this run and is left to the monitor
// Notes: array words outside erased sectors start unknown
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, g); error_cnt++; end end
module flash_command_sequencer_bench;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic prog_pin = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, s;
   logic [15:0] q;
   logic busy, ident, wprot, rprot;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   flash_bus_if bus_i();
   flash_command_sequencer #(.VENDOR_ID(8'h5A), .MACRO_ID(8'h11), .SIZE_ID(8'h22))
      i_flash_command_sequencer (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .bus(bus_i), .programmer_pin(prog_pin), .ident_active(ident), .auto_busy(busy),
      .read_protected(rprot), .write_protected(wprot));
   flash_seq_controller i_flash_seq_controller (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus(bus_i));
   flash_bus_monitor i_flash_bus_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .addr(bus_i.addr), .wdata(bus_i.wdata), .wr(bus_i.wr), .rd(bus_i.rd),
      .rdata(bus_i.rdata), .programmer_pin(prog_pin), .auto_busy(busy));
   always #10 sys_clk = ~sys_clk;
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // the run needs about 13500 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : reg_read
   task automatic flash_op(input flash_seq_pkg::host_op_t op, input logic [23:0] a,
         input logic [15:0] d);
      reg_write(`HC_ADDR_OFS, {8'h00, a});
      reg_write(`HC_DATA_OFS, {16'h0000, d});
      reg_write(`HC_CTRL_OFS, {29'h0, op});
      s = 32'h1;
      for (int i = 0; i < 4000 && s[1:0] !== 2'b10; i++)
         reg_read(`HC_STAT_OFS, s);
      `CHK("op_done", 2'b10, s[1:0])
      reg_read(`HC_RDATA_OFS, s);
      q = s[15:0];
   endtask : flash_op
   task automatic read_check(input logic [23:0] a, input logic [15:0] e);
      flash_op(flash_seq_pkg::OP_READ, a, 16'h0000);
      `CHK("flash_word", e, q)
   endtask : read_check
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      flash_op(flash_seq_pkg::OP_SECT, 24'h001000, 16'h0000);
      read_check(24'h001002, 16'hFFFF);
      flash_op(flash_seq_pkg::OP_PROG, 24'h001004, 16'h1234);
      read_check(24'h001004, 16'h1234);
      flash_op(flash_seq_pkg::OP_PROG, 24'h002000, 16'h0F8F);
      read_check(24'h002000, 16'h0F8F);
      $display("test program_erase done");
      flash_op(flash_seq_pkg::OP_ID_ENTRY, 24'h000000, 16'h0000);
      `CHK("ident_on", 1'b1, ident)
      read_check(24'h000000, 16'h005A);
      read_check(24'h000002, 16'h0011);
      read_check(24'h000004, 16'h0022);
      read_check(24'h00077E, 16'h00FF);
      // the programmed word hides behind the size id, offsets match on low bits
      read_check(24'h001004, 16'h0022);
      flash_op(flash_seq_pkg::OP_ID_EXIT, 24'h000000, 16'h0000);
      `CHK("ident_off", 1'b0, ident)
      read_check(24'h001004, 16'h1234);
      $display("test ident done");
      @(posedge sys_clk) prog_pin <= 1'b1;
      flash_op(flash_seq_pkg::OP_SECT, 24'h001000, 16'h0000);
      read_check(24'h001004, 16'h1234);
      @(posedge sys_clk) prog_pin <= 1'b0;
      flash_op(flash_seq_pkg::OP_SECT, 24'h001FFE, 16'h0000);
      read_check(24'h001004, 16'hFFFF);
      read_check(24'h002000, 16'h0F8F);
      $display("test sector done");
      // polls land in an erased sector: words there read FFFF, so two equal reads end the wait
      flash_op(flash_seq_pkg::OP_WPROT, 24'h00177E, 16'h0000);
      `CHK("write_prot", 1'b1, wprot)
      `CHK("read_prot", 1'b0, rprot)
      flash_op(flash_seq_pkg::OP_ID_ENTRY, 24'h000000, 16'h0000);
      read_check(24'h00077E, 16'h000F);
      reg_read(8'h20, s);
      `CHK("unmapped", 32'h0, s)
      $display("test protect done");
      test_done();
   end
endmodule : flash_command_sequencer_bench
